// [pcgr_pkg.sv]
/*
  Package for the peripheral clock gate and soft reset block: register
  offsets, field positions, masks, reset values and power modes.
  Assumes an APB slave with 32-bit data, byte addresses relative to the
  block base.
*/
package pcgr_pkg;

  localparam logic [31:0] PCGR_BASE_ADDR    = 32'h400FE000;
  localparam int          PCGR_ADDR_W       = 12;

  // printed offsets, all multiples of four, used as byte addresses
  localparam logic [11:0] PCGR_OFS_SOFT_RST = 12'h040;
  localparam logic [11:0] PCGR_OFS_RUN_GATE = 12'h108;
  localparam logic [11:0] PCGR_OFS_SLP_GATE = 12'h118;
  localparam logic [11:0] PCGR_OFS_DSL_GATE = 12'h128;
  localparam logic [11:0] PCGR_OFS_RUN_CFG  = 12'h200;
  localparam logic [11:0] PCGR_OFS_CAP_MASK = 12'h204;
  localparam logic [11:0] PCGR_OFS_MODE     = 12'h208;
  localparam logic [11:0] PCGR_OFS_INT_STAT = 12'h20C;
  localparam logic [11:0] PCGR_OFS_INT_MASK = 12'h210;

  // gate bank fields
  localparam int PCGR_BIT_SERIAL_BUS = 16;
  localparam int PCGR_BIT_DMA        = 13;
  localparam int PCGR_BIT_PORT_A     = 0;
  localparam int PCGR_NUM_PORTS      = 8;
  localparam int PCGR_NUM_GATES      = 10;
  localparam logic [31:0] PCGR_GATE_MASK = 32'h000120FF;
  localparam logic [31:0] PCGR_GATE_RST  = 32'h00000000;

  // soft reset bank fields
  localparam int PCGR_BIT_BUS_CTRL_SECOND = 25;
  localparam int PCGR_BIT_BUS_CTRL_FIRST  = 24;
  localparam int PCGR_BIT_PWM             = 20;
  localparam int PCGR_BIT_ADC             = 16;
  localparam int PCGR_BIT_HIB             = 6;
  localparam int PCGR_BIT_WDT             = 3;
  localparam int PCGR_NUM_RESETS          = 6;
  localparam logic [31:0] PCGR_SRST_MASK  = 32'h03110048;
  localparam logic [31:0] PCGR_SRST_RST   = 32'h00000000;

  // run clock config: automatic gating bit
  localparam int          PCGR_BIT_AUTO_GATING = 27;
  localparam logic [31:0] PCGR_RUN_CFG_MASK    = 32'h08000000;
  localparam logic [31:0] PCGR_RUN_CFG_RST     = 32'h00000000;

  // interrupt status: bit 0 gated access fault, bit 1 mode change
  localparam int          PCGR_IRQ_FAULT = 0;
  localparam int          PCGR_IRQ_MODE  = 1;
  localparam logic [31:0] PCGR_IRQ_MASK  = 32'h00000003;

  typedef enum logic [1:0] {
    PCGR_MODE_RUN,
    PCGR_MODE_SLEEP,
    PCGR_MODE_DEEP
  } pcgr_mode_t;

endpackage : pcgr_pkg

// [pcgr_top.sv]
/*
  Peripheral clock gating and software reset control. APB slave holding
  the run, sleep and deep-sleep gate banks, the run clock config, the
  soft reset bank and a small interrupt pair.
  Assumes one 50 MHz clock, synchronous active-high reset, a power
  manager giving the current mode, and a fabric that reports which gated
  unit a peripheral access targets.
*/
// The APB interface to the registers was decided locally.
module pcgr_top
  import pcgr_pkg::*;
#(
  parameter logic [31:0] CAP_MASK_RST = 32'h03110048
) (
  input  wire logic                          clk_i,
  input  wire logic                          rst_i,
  input  wire logic                          psel_i,
  input  wire logic                          penable_i,
  input  wire logic                          pwrite_i,
  input  wire logic [31:0]                   paddr_i,
  input  wire logic [31:0]                   pwdata_i,
  output logic      [31:0]                   prdata_o,
  output logic                               pready_o,
  output logic                               pslverr_o,
  input  wire pcgr_pkg::pcgr_mode_t          mode_i,
  input  wire logic                          periph_req_i,
  input  wire logic [pcgr_pkg::PCGR_NUM_GATES-1:0] periph_sel_i,
  output logic                               periph_fault_o,
  output logic      [pcgr_pkg::PCGR_NUM_PORTS-1:0] port_clk_en_o,
  output logic                               serial_bus_clk_en_o,
  output logic                               dma_clk_en_o,
  output logic                               bus_ctrl_first_rst_o,
  output logic                               bus_ctrl_second_rst_o,
  output logic                               pwm_rst_o,
  output logic                               adc_rst_o,
  output logic                               hib_rst_o,
  output logic                               wdt_rst_o,
  output logic                               irq_o
);
  import pcgr_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // registers and decode

  logic [31:0] run_gate_bank_r;
  logic [31:0] sleep_gate_bank_r;
  logic [31:0] deep_sleep_gate_bank_r;
  logic [31:0] run_clock_config_r;
  logic [31:0] capability_mask_1_r;
  logic [31:0] soft_reset_bank_0_r;
  logic [31:0] int_stat_r;
  logic [31:0] int_mask_r;
  logic [31:0] active_gate;
  logic [31:0] gate_en_r;
  pcgr_mode_t  mode_r;
  logic [31:0] rdata_nxt;
  logic        hit;
  logic        wr_go;
  logic        rd_go;
  logic        stat_rd;
  logic        in_block;
  logic [11:0] ofs;
  logic        fault_evt;
  logic        mode_evt;

  // block window is 4 KiB above the base; other addresses answer error
  assign in_block = (paddr_i[31:PCGR_ADDR_W] == PCGR_BASE_ADDR[31:PCGR_ADDR_W]);
  assign ofs      = paddr_i[PCGR_ADDR_W-1:0];
  assign wr_go    = psel_i & penable_i & pwrite_i & hit;
  assign rd_go    = psel_i & penable_i & ~pwrite_i & hit;
  assign stat_rd  = rd_go & (ofs == PCGR_OFS_INT_STAT);

  // zero wait states: every access completes in its access phase
  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i & penable_i & ~hit;

  // read mux; reserved bits held zero in storage, so read zero
  always_comb begin
    hit       = in_block;
    rdata_nxt = 32'h00000000;
    case (ofs)
      PCGR_OFS_SOFT_RST: rdata_nxt = soft_reset_bank_0_r;
      PCGR_OFS_RUN_GATE: rdata_nxt = run_gate_bank_r;
      PCGR_OFS_SLP_GATE: rdata_nxt = sleep_gate_bank_r;
      PCGR_OFS_DSL_GATE: rdata_nxt = deep_sleep_gate_bank_r;
      PCGR_OFS_RUN_CFG:  rdata_nxt = run_clock_config_r;
      PCGR_OFS_CAP_MASK: rdata_nxt = capability_mask_1_r;
      PCGR_OFS_MODE:     rdata_nxt = {30'h00000000, mode_r};
      PCGR_OFS_INT_STAT: rdata_nxt = int_stat_r;
      PCGR_OFS_INT_MASK: rdata_nxt = int_mask_r;
      default:           hit       = 1'b0;
    endcase
  end

  // read data registered at the setup edge so it is stable in access
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prdata_o <= 32'h00000000;
    end else if (psel_i & ~penable_i & ~pwrite_i & hit) begin
      prdata_o <= rdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // gate banks

  // all banks clear at reset; reserved bits masked off on write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_gate_bank_r        <= PCGR_GATE_RST;
      sleep_gate_bank_r      <= PCGR_GATE_RST;
      deep_sleep_gate_bank_r <= PCGR_GATE_RST;
    end else if (wr_go) begin
      if (ofs == PCGR_OFS_RUN_GATE) begin
        run_gate_bank_r <= pwdata_i & PCGR_GATE_MASK;
      end
      if (ofs == PCGR_OFS_SLP_GATE) begin
        sleep_gate_bank_r <= pwdata_i & PCGR_GATE_MASK;
      end
      if (ofs == PCGR_OFS_DSL_GATE) begin
        deep_sleep_gate_bank_r <= pwdata_i & PCGR_GATE_MASK;
      end
    end
  end

  // run clock config holds only the automatic gating bit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_clock_config_r <= PCGR_RUN_CFG_RST;
    end else if (wr_go && ofs == PCGR_OFS_RUN_CFG) begin
      run_clock_config_r <= pwdata_i & PCGR_RUN_CFG_MASK;
    end
  end

  // mode register tracks the power manager; used for change events
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_r <= PCGR_MODE_RUN;
    end else begin
      mode_r <= mode_i;
    end
  end

  // bank selection; sleep banks only count under auto gating
  always_comb begin
    active_gate = run_gate_bank_r;
    if (run_clock_config_r[PCGR_BIT_AUTO_GATING]) begin
      case (mode_r)
        PCGR_MODE_SLEEP: active_gate = sleep_gate_bank_r;
        PCGR_MODE_DEEP:  active_gate = deep_sleep_gate_bank_r;
        default:         active_gate = run_gate_bank_r;
      endcase
    end
  end

  // enables registered so the clock gate cells see glitch-free levels
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gate_en_r <= PCGR_GATE_RST;
    end else begin
      gate_en_r <= active_gate;
    end
  end

  assign port_clk_en_o       = gate_en_r[PCGR_BIT_PORT_A +: PCGR_NUM_PORTS];
  assign serial_bus_clk_en_o = gate_en_r[PCGR_BIT_SERIAL_BUS];
  assign dma_clk_en_o        = gate_en_r[PCGR_BIT_DMA];

  // access to a unit whose clock is off gets a fault, never a real cycle
  assign periph_fault_o = periph_req_i &
                          |(periph_sel_i & ~{gate_en_r[PCGR_BIT_SERIAL_BUS], gate_en_r[PCGR_BIT_DMA],
                                             gate_en_r[PCGR_NUM_PORTS-1:0]});

  ////////////////////////////////////////////////////////////////////////
  // soft reset bank

  // capability mask written once after reset by boot software if needed
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      capability_mask_1_r <= CAP_MASK_RST & PCGR_SRST_MASK;
    end else if (wr_go && ofs == PCGR_OFS_CAP_MASK) begin
      capability_mask_1_r <= pwdata_i & PCGR_SRST_MASK;
    end
  end

  // absent units keep their bit; only present ones take the write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      soft_reset_bank_0_r <= PCGR_SRST_RST;
    end else if (wr_go && ofs == PCGR_OFS_SOFT_RST) begin
      soft_reset_bank_0_r <= (pwdata_i & capability_mask_1_r & PCGR_SRST_MASK) |
                             (soft_reset_bank_0_r & ~capability_mask_1_r);
    end
  end

  // resets follow the bank level: held while one, released at zero
  assign bus_ctrl_second_rst_o = soft_reset_bank_0_r[PCGR_BIT_BUS_CTRL_SECOND];
  assign bus_ctrl_first_rst_o  = soft_reset_bank_0_r[PCGR_BIT_BUS_CTRL_FIRST];
  assign pwm_rst_o             = soft_reset_bank_0_r[PCGR_BIT_PWM];
  assign adc_rst_o             = soft_reset_bank_0_r[PCGR_BIT_ADC];
  assign hib_rst_o             = soft_reset_bank_0_r[PCGR_BIT_HIB];
  assign wdt_rst_o             = soft_reset_bank_0_r[PCGR_BIT_WDT];

  ////////////////////////////////////////////////////////////////////////
  // interrupts

  assign fault_evt = periph_fault_o;
  assign mode_evt  = (mode_i != mode_r);

  // sticky status, cleared by reading it; a new event wins over the clear.
  // only bits captured into prdata at setup are cleared, so an event that
  // lands between setup and access is kept for the next read
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      int_stat_r <= 32'h00000000;
    end else begin
      int_stat_r[PCGR_IRQ_FAULT] <= fault_evt |
                                    (int_stat_r[PCGR_IRQ_FAULT] & ~(stat_rd & prdata_o[PCGR_IRQ_FAULT]));
      int_stat_r[PCGR_IRQ_MODE]  <= mode_evt |
                                    (int_stat_r[PCGR_IRQ_MODE] & ~(stat_rd & prdata_o[PCGR_IRQ_MODE]));
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      int_mask_r <= 32'h00000000;
    end else if (wr_go && ofs == PCGR_OFS_INT_MASK) begin
      int_mask_r <= pwdata_i & PCGR_IRQ_MASK;
    end
  end

  assign irq_o = |(int_stat_r & int_mask_r);

endmodule : pcgr_top

// [pcgr_chk.sv]
/*
  assertion checker for pcgr_top, bound to its ports
  assumes capability bits of the reset units under test are set
*/
module pcgr_chk
  import pcgr_pkg::*;
#(parameter logic [31:0] CAP_MASK_RST = 32'h03110048) (
  input wire logic                 clk_i, rst_i, psel_i, penable_i, pwrite_i,
  input wire logic [31:0]          paddr_i, pwdata_i, prdata_o,
  input wire logic                 pslverr_o, periph_req_i, periph_fault_o,
  input wire pcgr_pkg::pcgr_mode_t mode_i,
  input wire logic [9:0]           periph_sel_i,
  input wire logic [7:0]           port_clk_en_o,
  input wire logic                 serial_bus_clk_en_o, dma_clk_en_o, pwm_rst_o,
  input wire logic                 bus_ctrl_first_rst_o, bus_ctrl_second_rst_o,
  input wire logic                 adc_rst_o, hib_rst_o, wdt_rst_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [9:0] en;
  logic [4:0] rv;
  logic       acc, w_run, w_srst;
  ////////////////////////////////////////////////////////////
  // decoded access phases, enables in select order
  assign en     = {serial_bus_clk_en_o, dma_clk_en_o, port_clk_en_o};
  assign rv     = {bus_ctrl_second_rst_o, bus_ctrl_first_rst_o, adc_rst_o, hib_rst_o, wdt_rst_o};
  assign acc    = psel_i && penable_i;
  assign w_run  = acc && pwrite_i && paddr_i == PCGR_BASE_ADDR + PCGR_OFS_RUN_GATE;
  assign w_srst = acc && pwrite_i && paddr_i == PCGR_BASE_ADDR + PCGR_OFS_SOFT_RST;
  function automatic logic [9:0] gsel(logic [31:0] b);
    return {b[16], b[13], b[7:0]};
  endfunction : gsel
  ////////////////////////////////////////////////////////////
  gate_reset_a: assert property (disable iff (1'b0) rst_i |=> en == 10'h000)
    else $error("enables not cleared by reset");
  fault_a: assert property (periph_fault_o == (periph_req_i && !(|(periph_sel_i & en))))
    else $error("fault answer wrong");
  outside_a: assert property (acc && paddr_i[31:12] != 20'h400FE |-> pslverr_o)
    else $error("outside access not refused");
  rsvd_a: assert property (acc && !pwrite_i && paddr_i == PCGR_BASE_ADDR + PCGR_OFS_SLP_GATE
    |-> (prdata_o & ~PCGR_GATE_MASK) == 32'h00000000 && !pslverr_o) else $error("reserved bits set");
  run_gate_a: assert property (w_run && mode_i == PCGR_MODE_RUN |-> ##2 en == gsel($past(pwdata_i, 2)))
    else $error("run bank not applied");
  srst_a: assert property (w_srst |=> rv == {$past(pwdata_i[25:24]), $past(pwdata_i[16]), $past(pwdata_i[6]), $past(pwdata_i[3])})
    else $error("reset pins do not follow write");
  srst_hold_a: assert property (!w_srst |=> $stable(rv) && $stable(pwm_rst_o))
    else $error("reset pins moved without write");
  pwm_mask_a: assert property (!CAP_MASK_RST[20] |-> !pwm_rst_o)
    else $error("absent unit reset set");
  cover property (periph_fault_o);
  cover property (w_srst);
  cover property (mode_i == PCGR_MODE_DEEP && |en);
endmodule : pcgr_chk

bind pcgr_top pcgr_chk #(.CAP_MASK_RST(CAP_MASK_RST)) i_pcgr_chk (.*);

// [pcgr_periph_model.sv]
/*
  model of the gated units and the fabric in front of them
  assumes enables arrive in select order: serial bus, dma, ports H..A
*/
module pcgr_periph_model (
  input  wire logic       clk_i,
  input  wire logic       clr_i,
  input  wire logic [9:0] unit_clk_en_i,
  input  wire logic       go_i,
  input  wire logic [3:0] pick_i,
  output logic            periph_req_o,
  output logic [9:0]      periph_sel_o,
  output logic [9:0][7:0] ticks_o
);
  // fabric: one-hot target, no target while idle
  assign periph_req_o = go_i;
  assign periph_sel_o = go_i ? 10'h001 << pick_i : 10'h000;
  // a unit only advances while clocked
  always_ff @(posedge clk_i) begin
    for (int i = 0; i < 10; i++) begin
      if (clr_i) ticks_o[i] <= 8'h00;
      else if (unit_clk_en_i[i]) ticks_o[i] <= ticks_o[i] + 8'h01;
    end
  end
endmodule : pcgr_periph_model

// [pcgr_top_tb.sv]
/*
  self-checking bench for pcgr_top with an APB master
  assumes zero-wait slave; pulse-width unit marked absent
*/
module pcgr_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import pcgr_pkg::*;
  localparam logic [31:0] CAP = 32'h03010048; // pulse-width unit absent
  logic clk_i, rst_i, psel_i, penable_i, pwrite_i, periph_req_i, periph_fault_o, pready_o, pslverr_o, irq_o;
  logic serial_bus_clk_en_o, dma_clk_en_o, bus_ctrl_first_rst_o, bus_ctrl_second_rst_o;
  logic pwm_rst_o, adc_rst_o, hib_rst_o, wdt_rst_o, go, clr, e;
  logic [31:0] paddr_i, pwdata_i, prdata_o, q, en_v, rv;
  logic [9:0] periph_sel_i;
  logic [7:0] port_clk_en_o;
  logic [9:0][7:0] ticks;
  logic [3:0] pick;
  pcgr_mode_t mode_i;
  int fails, n_checks;
  assign en_v = {22'h0, serial_bus_clk_en_o, dma_clk_en_o, port_clk_en_o};
  assign rv = {26'h0, bus_ctrl_second_rst_o, bus_ctrl_first_rst_o, pwm_rst_o, adc_rst_o, hib_rst_o, wdt_rst_o};
  pcgr_top #(.CAP_MASK_RST(CAP)) i_pcgr_top (.*);
  pcgr_periph_model i_pcgr_periph_model (.clk_i(clk_i), .clr_i(clr), .go_i(go), .pick_i(pick),
    .unit_clk_en_i(en_v[9:0]), .periph_req_o(periph_req_i), .periph_sel_o(periph_sel_i), .ticks_o(ticks));
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  ////////////////////////////////////////////////////////////
  task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("wrong value %s exp %h got %h", nm, exp, got);
      fails++;
    end
  endtask : chk
  task automatic results();
    if (fails == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : results
  // one APB transfer: setup, then access until pready
  task automatic apb(logic w, logic [31:0] a, logic [31:0] d);
    int n;
    @(posedge clk_i);
    psel_i <= 1'b1; penable_i <= 1'b0; pwrite_i <= w; paddr_i <= PCGR_BASE_ADDR + a; pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge clk_i);
      if (pready_o === 1'b1) break;
    end
    if (n == 16) begin
      fails++;
      results();
    end
    q = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb
  task automatic rc(string nm, logic [31:0] a, logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(nm, q, x);
  endtask : rc
  task automatic mset(pcgr_mode_t m);
    @(posedge clk_i);
    mode_i <= m;
    repeat (3) @(posedge clk_i);
  endtask : mset
  function automatic logic [31:0] gv(logic [31:0] b);
    return {22'h0, b[16], b[13], b[7:0]};
  endfunction : gv
  ////////////////////////////////////////////////////////////
  task automatic t_regs();
    logic [11:0] o [3] = '{PCGR_OFS_RUN_GATE, PCGR_OFS_SLP_GATE, PCGR_OFS_DSL_GATE};
    chk("gates after reset", en_v, 32'h0);
    rc("srst after reset", PCGR_OFS_SOFT_RST, 32'h0);
    foreach (o[i]) begin
      rc("gate after reset", o[i], 32'h0);
      apb(1'b1, o[i], 32'hFFFFFFFF);
      rc("gate readback", o[i], 32'h000120FF);
      chk("mapped err", e, 32'h0);
      apb(1'b1, o[i], 32'h0);
    end
    apb(1'b0, 32'h044, 32'h0);
    chk("unmapped err", e, 32'h1);
    apb(1'b0, 32'h1118, 32'h0);
    chk("outside err", e, 32'h1);
  endtask : t_regs
  task automatic t_modes();
    apb(1'b1, PCGR_OFS_RUN_GATE, 32'h00000001);
    apb(1'b1, PCGR_OFS_SLP_GATE, 32'h00012080);
    apb(1'b1, PCGR_OFS_DSL_GATE, 32'h00000042);
    mset(PCGR_MODE_SLEEP);
    chk("sleep no auto", en_v, gv(32'h1));
    apb(1'b1, PCGR_OFS_RUN_CFG, 32'h08000000);
    mset(PCGR_MODE_SLEEP);
    chk("sleep bank", en_v, gv(32'h00012080));
    mset(PCGR_MODE_DEEP);
    chk("deep bank", en_v, gv(32'h42));
    mset(PCGR_MODE_RUN);
    chk("run bank", en_v, gv(32'h1));
    clr <= 1'b1;
    @(posedge clk_i);
    clr <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk("port a runs", {31'h0, ticks[0] != 8'h00}, 32'h1);
    chk("port b still", {24'h0, ticks[1]}, 32'h0);
  endtask : t_modes
  task automatic t_srst();
    int b [6] = '{25, 24, 20, 16, 6, 3};
    foreach (b[i]) begin
      apb(1'b1, PCGR_OFS_SOFT_RST, 32'h1 << b[i]);
      rc("srst readback", PCGR_OFS_SOFT_RST, (32'h1 << b[i]) & CAP);
      chk("reset pins", rv, i == 2 ? 32'h0 : 32'h20 >> i);
    end
    apb(1'b1, PCGR_OFS_SOFT_RST, 32'h0);
    @(posedge clk_i);
    chk("reset released", rv, 32'h0);
  endtask : t_srst
  task automatic t_fault();
    apb(1'b1, PCGR_OFS_INT_MASK, 32'h1);
    rc("mode event", PCGR_OFS_INT_STAT, 32'h2);
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_i);
      go <= 1'b1;
      pick <= 4'(i);
      @(posedge clk_i);
      chk("fault", {31'h0, periph_fault_o}, 32'(i));
      go <= 1'b0;
    end
    @(posedge clk_i);
    chk("irq raised", {31'h0, irq_o}, 32'h1);
    rc("status", PCGR_OFS_INT_STAT, 32'h1);
    @(posedge clk_i);
    chk("irq cleared", {31'h0, irq_o}, 32'h0);
  endtask : t_fault
  ////////////////////////////////////////////////////////////
  initial begin
    rst_i = 1'b1;
    {psel_i, penable_i, pwrite_i, go, clr} = 5'h00;
    {paddr_i, pwdata_i} = 64'h0;
    pick = 4'h0;
    mode_i = PCGR_MODE_RUN;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_modes();
    t_srst();
    t_fault();
    results();
  end
endmodule : pcgr_top_tb
